// File: design/ssl_pkg.sv
// Constants for the setting switch loader
`default_nettype none
package ssl_pkg;
    localparam logic [3:0] SSL_RATE_625K = 4'h7;
    localparam logic [3:0] SSL_RATE_BAD_MIN = 4'h8;
    localparam logic [7:0] SSL_ADDR_MIN = 8'h03;
    localparam logic [7:0] SSL_ADDR_MAX = 8'hEF;
    localparam logic [7:0] SSL_ADDR_RESET = 8'h61;
    localparam logic [3:0] SSL_RATE_RESET = 4'h7;
    localparam logic [2:0] SSL_MODE_RESET = 3'h4;
    localparam logic [6:0] SSL_BYTES_16 = 7'h10;
    localparam logic [6:0] SSL_BYTES_32 = 7'h20;
    localparam logic [6:0] SSL_BYTES_48 = 7'h30;
    localparam logic [6:0] SSL_BYTES_64 = 7'h40;
    localparam logic [4:0] SSL_UNITS_16BIT = 5'h08;
    localparam logic [4:0] SSL_UNITS_8BIT = 5'h10;
    localparam int SSL_MODE_SIZE_BIT = 0;
    localparam int SSL_MODE_BYTES_HI = 1;
    localparam int SSL_MODE_BYTES_LO = 2;
    // Register map on the plain register port
    localparam logic [3:0] SSL_REG_SETTINGS = 4'h0;
    localparam logic [3:0] SSL_REG_STATUS = 4'h1;
    localparam logic [3:0] SSL_REG_MASK = 4'h2;
    localparam int SSL_EV_RATE_ALARM = 0;
    localparam int SSL_EV_LINK_ERR = 1;
    localparam int SSL_EV_NET_ERR = 2;
    localparam int SSL_EV_BAD_ADDR = 3;
    localparam logic [3:0] SSL_MASK_RESET = 4'h0;
endpackage
`default_nettype wire

// File: design/ssl_loader.sv
// Setting switch capture, decode, alarm and error lamps
`default_nettype none
// Operation
// - A rate dial of 7 decodes as the 625 kbps link rate, and 7 is the shipped default.
// - A rate dial of 8 or more at power-on raises the switch setting alarm.
// - Rate dial values 0 to 6 are unusable but raise no alarm.
// - Switch moves while powered have no effect until the next power cycle.
// - Mode switch one off gives 16 bit mode with 8 units, on gives 8 bit mode with 16.
// - Mode switches two and three pick 16, 32, 48 or 64 transmission bytes.
// - Shipped mode defaults are one off, two off, three on.
// - The fourth mode switch has no effect on anything.
// - The station address is tens dial high digit, ones dial low digit, valid 03h to EFh.
// - Addresses 00h to 02h and F0h to FFh are not usable for this device.
// - The shipped station address is 61h.
// - A change of the downstream connection enable takes effect only after a power cycle.
// - A link error lights the serial error lamp, a network error the network error lamp.
module ssl_loader
    import ssl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] rate_select_dial,
    input wire logic [3:0] mode_switch_bank,
    input wire logic [3:0] station_tens_dial,
    input wire logic [3:0] station_ones_dial,
    input wire logic [15:0] conn_enable_param,
    input wire logic link_comm_error,
    input wire logic net_comm_error,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic settings_valid,
    output logic rate_ok,
    output logic rate_alarm,
    output logic size_8bit,
    output logic [4:0] max_units,
    output logic [6:0] tx_bytes,
    output logic [7:0] station_addr,
    output logic station_addr_bad,
    output logic [15:0] conn_enable,
    output logic link_err_lamp,
    output logic net_err_lamp,
    output logic irq
);
    // Two-flop synchronisers for the setting and error pins, except mode switch four
    logic [32:0] pins_s1_q;
    logic [32:0] pins_s2_q;
    logic sample_q;
    logic loaded_q;
    logic [3:0] rate_q;
    logic [2:0] mode_q;
    logic [3:0] status_q;
    logic [3:0] mask_q;
    logic [3:0] ev_set;

    always_ff @(posedge clock) begin
        pins_s1_q <= {conn_enable_param, station_tens_dial, station_ones_dial,
                      mode_switch_bank[2:0], rate_select_dial, net_comm_error, link_comm_error};
        pins_s2_q <= pins_s1_q;
    end

    // Wait one extra edge so the synchroniser holds post-reset pin values
    always_ff @(posedge clock) begin
        if (reset) begin
            sample_q <= 1'b0;
            loaded_q <= 1'b0;
        end else begin
            sample_q <= 1'b1;
            loaded_q <= loaded_q | sample_q;
        end
    end

    // Capture once; later switch moves are ignored until reset
    always_ff @(posedge clock) begin
        if (reset) begin
            rate_q <= SSL_RATE_RESET;
            mode_q <= SSL_MODE_RESET;
            station_addr <= SSL_ADDR_RESET;
            conn_enable <= 16'h0000;
        end else if (sample_q && !loaded_q) begin
            rate_q <= pins_s2_q[5:2];
            mode_q <= pins_s2_q[8:6];
            station_addr <= {pins_s2_q[16:13], pins_s2_q[12:9]};
            conn_enable <= pins_s2_q[32:17];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            settings_valid <= 1'b0;
            rate_ok <= 1'b0;
            rate_alarm <= 1'b0;
            size_8bit <= 1'b0;
            max_units <= SSL_UNITS_16BIT;
            tx_bytes <= SSL_BYTES_32;
            station_addr_bad <= 1'b0;
        end else begin
            settings_valid <= loaded_q;
            rate_ok <= (rate_q == SSL_RATE_625K);
            rate_alarm <= loaded_q && (rate_q >= SSL_RATE_BAD_MIN);
            size_8bit <= mode_q[SSL_MODE_SIZE_BIT];
            max_units <= mode_q[SSL_MODE_SIZE_BIT] ? SSL_UNITS_8BIT : SSL_UNITS_16BIT;
            unique case ({mode_q[SSL_MODE_BYTES_HI], mode_q[SSL_MODE_BYTES_LO]})
                2'b00: tx_bytes <= SSL_BYTES_16;
                2'b01: tx_bytes <= SSL_BYTES_32;
                2'b10: tx_bytes <= SSL_BYTES_48;
                2'b11: tx_bytes <= SSL_BYTES_64;
            endcase
            station_addr_bad <= loaded_q &&
                (station_addr < SSL_ADDR_MIN || station_addr > SSL_ADDR_MAX);
        end
    end

    // Error lamps follow the synchronised error levels
    always_ff @(posedge clock) begin
        if (reset) begin
            link_err_lamp <= 1'b0;
            net_err_lamp <= 1'b0;
        end else begin
            link_err_lamp <= pins_s2_q[0];
            net_err_lamp <= pins_s2_q[1];
        end
    end

    assign ev_set[SSL_EV_RATE_ALARM] = rate_alarm;
    assign ev_set[SSL_EV_LINK_ERR] = link_err_lamp;
    assign ev_set[SSL_EV_NET_ERR] = net_err_lamp;
    assign ev_set[SSL_EV_BAD_ADDR] = station_addr_bad;

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clock) begin
        if (reset) begin
            status_q <= 4'h0;
        end else if (reg_write && reg_addr == SSL_REG_STATUS) begin
            status_q <= (status_q & ~reg_wdata[3:0]) | ev_set;
        end else begin
            status_q <= status_q | ev_set;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mask_q <= SSL_MASK_RESET;
        end else if (reg_write && reg_addr == SSL_REG_MASK) begin
            mask_q <= reg_wdata[3:0];
        end
    end

    // Interrupt follows masked status of the previous cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                SSL_REG_SETTINGS: reg_rdata <= {rate_q, 1'b0, mode_q};
                SSL_REG_STATUS: reg_rdata <= {4'h0, status_q};
                SSL_REG_MASK: reg_rdata <= {4'h0, mask_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    property p_rate_alarm;
        @(posedge clock) disable iff (reset)
        loaded_q && (rate_q >= SSL_RATE_BAD_MIN) |=> rate_alarm;
    endproperty
    a_rate_alarm: assert property (p_rate_alarm) else $error("rate alarm missing");

    property p_no_low_alarm;
        @(posedge clock) disable iff (reset)
        rate_q < SSL_RATE_BAD_MIN |=> !rate_alarm;
    endproperty
    a_no_low_alarm: assert property (p_no_low_alarm) else $error("alarm on low rate");

    property p_rate_ok;
        @(posedge clock) disable iff (reset)
        rate_q == SSL_RATE_625K |=> rate_ok;
    endproperty
    a_rate_ok: assert property (p_rate_ok) else $error("rate 7 not decoded");

    property p_hold;
        @(posedge clock) disable iff (reset)
        loaded_q |=> $stable(station_addr) && $stable(rate_q) && $stable(mode_q);
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed after load");

    property p_size;
        @(posedge clock) disable iff (reset)
        1'b1 |=> size_8bit == $past(mode_q[0]) && max_units ==
            ($past(mode_q[0]) ? SSL_UNITS_8BIT : SSL_UNITS_16BIT);
    endproperty
    a_size: assert property (p_size) else $error("size mode wrong");

    property p_bytes;
        @(posedge clock) disable iff (reset)
        mode_q[1] && !mode_q[2] |=> tx_bytes == SSL_BYTES_48;
    endproperty
    a_bytes: assert property (p_bytes) else $error("byte count wrong");

    property p_addr_bad;
        @(posedge clock) disable iff (reset)
        loaded_q && station_addr > SSL_ADDR_MAX |=> station_addr_bad;
    endproperty
    a_addr_bad: assert property (p_addr_bad) else $error("bad address not flagged");

    property p_lamp;
        @(posedge clock) disable iff (reset)
        $rose(link_comm_error) |-> ##[3:4] link_err_lamp;
    endproperty
    a_lamp: assert property (p_lamp) else $error("link lamp late");

    property p_bytes_16;
        @(posedge clock) disable iff (reset)
        !mode_q[SSL_MODE_BYTES_HI] && !mode_q[SSL_MODE_BYTES_LO] |=> tx_bytes == SSL_BYTES_16;
    endproperty
    a_bytes_16: assert property (p_bytes_16) else $error("16 byte count wrong");

    property p_bytes_32;
        @(posedge clock) disable iff (reset)
        !mode_q[SSL_MODE_BYTES_HI] && mode_q[SSL_MODE_BYTES_LO] |=> tx_bytes == SSL_BYTES_32;
    endproperty
    a_bytes_32: assert property (p_bytes_32) else $error("32 byte count wrong");

    property p_bytes_64;
        @(posedge clock) disable iff (reset)
        mode_q[SSL_MODE_BYTES_HI] && mode_q[SSL_MODE_BYTES_LO] |=> tx_bytes == SSL_BYTES_64;
    endproperty
    a_bytes_64: assert property (p_bytes_64) else $error("64 byte count wrong");

    property p_addr_low;
        @(posedge clock) disable iff (reset)
        loaded_q && station_addr < SSL_ADDR_MIN |=> station_addr_bad;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("low address not flagged");

    property p_addr_good;
        @(posedge clock) disable iff (reset)
        loaded_q && station_addr >= SSL_ADDR_MIN && station_addr <= SSL_ADDR_MAX |=> !station_addr_bad;
    endproperty
    a_addr_good: assert property (p_addr_good) else $error("good address flagged");

    property p_rst_addr;
        @(posedge clock)
        reset |=> station_addr == SSL_ADDR_RESET;
    endproperty
    a_rst_addr: assert property (p_rst_addr) else $error("address default wrong");

    property p_rst_mode;
        @(posedge clock)
        reset |=> mode_q == SSL_MODE_RESET && rate_q == SSL_RATE_RESET;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("mode default wrong");

    property p_valid_on;
        @(posedge clock) disable iff (reset)
        loaded_q |=> settings_valid;
    endproperty
    a_valid_on: assert property (p_valid_on) else $error("settings not valid");

    property p_valid_off;
        @(posedge clock) disable iff (reset)
        !loaded_q |=> !settings_valid;
    endproperty
    a_valid_off: assert property (p_valid_off) else $error("settings valid early");

    property p_conn_hold;
        @(posedge clock) disable iff (reset)
        loaded_q |=> $stable(conn_enable);
    endproperty
    a_conn_hold: assert property (p_conn_hold) else $error("conn enable moved");

    property p_lamp_net;
        @(posedge clock) disable iff (reset)
        $rose(net_comm_error) |-> ##[3:4] net_err_lamp;
    endproperty
    a_lamp_net: assert property (p_lamp_net) else $error("net lamp late");

    property p_lamp_off;
        @(posedge clock) disable iff (reset)
        $fell(link_comm_error) |-> ##[3:4] !link_err_lamp;
    endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("link lamp stuck");

    property p_irq_on;
        @(posedge clock) disable iff (reset)
        |(status_q & mask_q) |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

    property p_status_set;
        @(posedge clock) disable iff (reset)
        |ev_set |=> (status_q & $past(ev_set)) == $past(ev_set);
    endproperty
    a_status_set: assert property (p_status_set) else $error("event lost");

    property p_rdata_idle;
        @(posedge clock) disable iff (reset)
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_no_early_alarm;
        @(posedge clock) disable iff (reset)
        !loaded_q |=> !rate_alarm && !station_addr_bad;
    endproperty
    a_no_early_alarm: assert property (p_no_early_alarm) else $error("alarm before load");
endmodule
`default_nettype wire

// File: bench/ssl_switch_model.sv
// Installer switch model driving the setting pins
`default_nettype none
module ssl_switch_model
(
    input wire logic [3:0] set_rate,
    input wire logic [3:0] set_mode,
    input wire logic [3:0] set_tens,
    input wire logic [3:0] set_ones,
    output logic [3:0] rate_select_dial,
    output logic [3:0] mode_switch_bank,
    output logic [3:0] station_tens_dial,
    output logic [3:0] station_ones_dial
);
    timeunit 1ns;
    timeprecision 1ps;
    // Static levels; contact bounce is not modelled
    assign rate_select_dial = set_rate;
    assign mode_switch_bank = set_mode;
    // Bench only picks addresses that no other node uses
    assign station_tens_dial = set_tens;
    assign station_ones_dial = set_ones;
endmodule
`default_nettype wire

// File: bench/tb_ssl_loader.sv
// Testbench for the setting switch loader
`default_nettype none
module tb_ssl_loader
    import ssl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0;
    logic reset = 1;
    logic [3:0] s_rate, s_mode, s_tens, s_ones, rate_select_dial, mode_switch_bank;
    logic [3:0] station_tens_dial, station_ones_dial, reg_addr, e_r, e_m;
    logic [15:0] conn_enable_param, conn_enable, e_ce;
    logic link_comm_error, net_comm_error, reg_write, reg_read, settings_valid, rate_ok;
    logic rate_alarm, size_8bit, station_addr_bad, link_err_lamp, net_err_lamp, irq;
    logic [7:0] reg_wdata, reg_rdata, station_addr, e_a;
    logic [4:0] max_units;
    logic [6:0] tx_bytes;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    ssl_switch_model ssl_switch_model_inst (.set_rate(s_rate), .set_mode(s_mode),
        .set_tens(s_tens), .set_ones(s_ones), .rate_select_dial(rate_select_dial),
        .mode_switch_bank(mode_switch_bank), .station_tens_dial(station_tens_dial),
        .station_ones_dial(station_ones_dial));
    ssl_loader ssl_loader_inst (.clock(clock), .reset(reset), .rate_select_dial(rate_select_dial),
        .mode_switch_bank(mode_switch_bank), .station_tens_dial(station_tens_dial),
        .station_ones_dial(station_ones_dial), .conn_enable_param(conn_enable_param),
        .link_comm_error(link_comm_error), .net_comm_error(net_comm_error),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .settings_valid(settings_valid),
        .rate_ok(rate_ok), .rate_alarm(rate_alarm), .size_8bit(size_8bit),
        .max_units(max_units), .tx_bytes(tx_bytes), .station_addr(station_addr),
        .station_addr_bad(station_addr_bad), .conn_enable(conn_enable),
        .link_err_lamp(link_err_lamp), .net_err_lamp(net_err_lamp), .irq(irq));
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(string n, logic [3:0] a, logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(n, reg_rdata, e);
    endtask
    task automatic wait_chk(string n, logic s_now_unused, int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic dec();
        chk("valid", settings_valid, 1'b1);
        chk("rate_ok", rate_ok, e_r == 4'h7);
        chk("alarm", rate_alarm, e_r >= 4'h8);
        chk("size", size_8bit, e_m[0]);
        chk("units", max_units, e_m[0] ? 5'h10 : 5'h08);
        chk("bytes", tx_bytes, 7'h10 * ({e_m[1], e_m[2]} + 1));
        chk("addr", station_addr, e_a);
        chk("addr_bad", station_addr_bad, e_a < 8'h03 || e_a > 8'hEF);
        chk("conn", conn_enable, e_ce);
    endtask
    // Pins move after capture to prove they are held until the next reset
    task automatic power(logic [3:0] r, logic [3:0] m, logic [3:0] t, logic [3:0] o,
            logic [15:0] ce);
        @(posedge clock);
        reset <= 1'b1;
        {s_rate, s_mode, s_tens, s_ones, conn_enable_param} <= {r, m, t, o, ce};
        {e_r, e_m, e_a, e_ce} = {r, m, t, o, ce};
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        #1 chk("rst_addr", station_addr, 8'h61);
        chk("rst_bytes", tx_bytes, 7'h20);
        chk("rst_size", size_8bit, 1'b0);
        wait_chk("", 1'b0, 6);
        dec();
        @(posedge clock);
        {s_rate, s_mode, s_tens, s_ones, conn_enable_param} <= ~{r, m, t, o, ce};
        wait_chk("", 1'b0, 8);
        dec();
    endtask
    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {s_rate, s_mode, s_tens, s_ones, conn_enable_param} = {4'h7, 4'h4, 4'h6, 4'h1, 16'h0};
        {link_comm_error, net_comm_error, reg_write, reg_read} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        power(4'h7, 4'h4, 4'h6, 4'h1, 16'hA5C3);
        power(4'h0, 4'hA, 4'hF, 4'h0, 16'h0001);
        power(4'h6, 4'hF, 4'h0, 4'h3, 16'h8000);
        power(4'hF, 4'hE, 4'hE, 4'hF, 16'h0000);
        power(4'h8, 4'h1, 4'h0, 4'h2, 16'hFFFF);
        rd("settings", 4'h0, 8'h81);
        wr(4'h0, 8'hFF);
        rd("settings_ro", 4'h0, 8'h81);
        rd("mask_rst", 4'h2, 8'h00);
        rd("unmapped", 4'h5, 8'h00);
        @(posedge clock);
        {link_comm_error, net_comm_error} <= 2'b11;
        wait_chk("", 1'b0, 6);
        chk("link_lamp", link_err_lamp, 1'b1);
        chk("net_lamp", net_err_lamp, 1'b1);
        @(posedge clock);
        {link_comm_error, net_comm_error} <= 2'b00;
        wait_chk("", 1'b0, 6);
        chk("link_off", link_err_lamp, 1'b0);
        chk("net_off", net_err_lamp, 1'b0);
        rd("status", 4'h1, 8'h0F);
        wr(4'h1, 8'h06);
        rd("status_clr", 4'h1, 8'h09);
        chk("irq_masked", irq, 1'b0);
        wr(4'h2, 8'h02);
        wait_chk("", 1'b0, 3);
        chk("irq_cleared", irq, 1'b0);
        wr(4'h2, 8'h01);
        wait_chk("", 1'b0, 3);
        chk("irq_on", irq, 1'b1);
        rd("mask", 4'h2, 8'h01);
        wr(4'h2, 8'h00);
        wait_chk("", 1'b0, 3);
        chk("irq_off", irq, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
